// [shared/mux_port_pkg.sv]
package mux_port_pkg;
   // widths of the shared memory path
   localparam int ADDR_W = 18;
   localparam int DATA_W = 36;
   // clock and timing
   localparam int CLOCK_PERIOD_NS = 25;
   // a memory that never accepts the address is taken as nonexistent after this wait
   localparam int NXM_TIMEOUT_NS = 10000;
   localparam int NXM_TIMEOUT_CYC_I = (NXM_TIMEOUT_NS / CLOCK_PERIOD_NS) < 1 ? 1 : (NXM_TIMEOUT_NS / CLOCK_PERIOD_NS);
   localparam int TMO_W = 16;
   localparam logic [TMO_W-1:0] NXM_TIMEOUT_CYC = TMO_W'(NXM_TIMEOUT_CYC_I);
   localparam logic [TMO_W-1:0] TMO_ZERO = 16'h0000;
   localparam logic [TMO_W-1:0] TMO_ONE = 16'h0001;
   // reset values
   localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;
   localparam logic [DATA_W-1:0] DATA_RESET = 36'h000000000;
   // cycle phases of the channel end
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_GRANT,
      ST_ADDRESS,
      ST_READ_DATA,
      ST_WRITE_DATA,
      ST_ABORT,
      ST_RELEASE
   } phase_t;
endpackage

// [design/word_buffer.sv]
`timescale 1ns/10ps
module word_buffer
   import mux_port_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic in_valid, // word offered
   output logic in_ready, // room for a word
   input wire logic [DATA_W-1:0] in_data, // word in
   output logic out_valid, // word available
   input wire logic out_ready, // receiver takes the word
   output logic [DATA_W-1:0] out_data // oldest word
);
   logic [DATA_W-1:0] mem_q [2]; // two storage slots
   logic [DATA_W-1:0] mem_d [2];
   logic wr_ptr_q, wr_ptr_d; // slot written next
   logic rd_ptr_q, rd_ptr_d; // slot read next
   logic [1:0] count_q, count_d; // words held
   logic push, pop;

   // handshake flags come straight from the count
   assign in_ready = (count_q != 2'h2);
   assign out_valid = (count_q != 2'h0);
   assign out_data = mem_q[rd_ptr_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // next pointers, count and slot contents
   always_comb begin
      mem_d = mem_q;
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      count_d = count_q;
      if (push) begin
         mem_d[wr_ptr_q] = in_data;
         wr_ptr_d = ~wr_ptr_q;
      end
      if (pop) begin
         rd_ptr_d = ~rd_ptr_q;
      end
      // simultaneous push and pop leave the count alone
      if (push && !pop) begin
         count_d = count_q + 2'h1;
      end else if (pop && !push) begin
         count_d = count_q - 2'h1;
      end
   end

   // register stage only
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mem_q[0] <= DATA_RESET;
         mem_q[1] <= DATA_RESET;
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'h0;
      end else begin
         mem_q <= mem_d;
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q <= count_d;
      end
   end
endmodule

// [design/channel_port_master.sv]
`timescale 1ns/10ps
// Behaviour
// [R01] channel holds its request level until served
// [R02] device latches requests only while not busy
// [R03] lower port number wins simultaneous requests
// [R04] upper ports granted only with upper enable
// [R05] device raises grant line of selected port
// [R06] delayed busy set before any grant
// [R07] busy flag marks occupied, clear ends cycle
// [R08] cycle request with address only after grant
// [R09] device forwards cycle request until address accept
// [R10] device relays address accept to channel
// [R11] device forwards read and write request levels
// [R12] read done reaches channel with read word
// [R13] delayed read done turns data toward memory
// [R14] direction flops choose data path direction
// [R15] read done clears unless write buffer set
// [R16] channel sends write done with write word
// [R17] device relays write done to memory
// [R18] delayed write done follows write done
// [R19] delayed write done clears when buffering write
// [R20] internal clear generates wrapup pulse
// [R21] delayed wrapup clears busy flag
// [R22] channel pulses abort on nonexistent memory
// [R23] device ORs abort pulses into clear
// [R24] device relays no-parity pulse to channel
// [R25] read-modify-write stays connected until write done
module channel_port_master
   import mux_port_pkg::*;
(
   input wire logic clock, // 40 MHz system clock
   input wire logic rst_n, // synchronous reset, active low
   // user side orders
   input wire logic cmd_valid, // order offered
   output logic cmd_ready, // order taken this cycle
   input wire logic cmd_read, // order reads memory
   input wire logic cmd_write, // order writes memory (both: read-modify-write)
   input wire logic [ADDR_W-1:0] cmd_addr, // memory address
   input wire logic [DATA_W-1:0] cmd_wdata, // word to write
   output logic rd_valid, // read word available
   input wire logic rd_ready, // user takes read word
   output logic [DATA_W-1:0] rd_data, // read word
   output logic abort_seen, // pulse: cycle given up, memory absent
   output logic no_parity_seen, // level: last cycle's memory keeps no parity
   output logic cycle_busy, // level: an order is in progress
   // control line to the multiplexor port
   output logic port_request, // request level on our control line
   input wire logic grant_level, // grant level from the multiplexor
   output logic channel_abort_pulse, // nonexistent memory pulse
   // channel side bus
   output logic channel_cycle_request, // cycle request level
   output logic [ADDR_W-1:0] bus_addr, // address word
   output logic channel_read_request, // read request level
   output logic channel_write_request, // write request level
   input wire logic channel_address_accept, // memory took the address
   input wire logic channel_read_done_pulse, // read word is on the bus
   input wire logic channel_no_parity_pulse, // memory has no parity bit
   output logic channel_write_done_pulse, // write word is on the bus
   input wire logic [DATA_W-1:0] bus_data_in, // data bus, level seen
   output logic [DATA_W-1:0] bus_data_out, // data bus, level driven
   output logic bus_data_oe // high while we drive the data bus
);
   phase_t phase_q, phase_d; // cycle phase
   logic req_q, req_d; // port request level
   logic cyc_q, cyc_d; // cycle request level
   logic rdr_q, rdr_d; // read request level
   logic wrr_q, wrr_d; // write request level
   logic wdone_q, wdone_d; // write done pulse
   logic oe_q, oe_d; // data drive enable
   logic abort_q, abort_d; // abort pulse toward multiplexor
   logic aseen_q, aseen_d; // abort pulse toward user
   logic nopar_q, nopar_d; // no-parity level toward user
   logic [ADDR_W-1:0] addr_q, addr_d; // held address
   logic [DATA_W-1:0] wdata_q, wdata_d; // held write word
   logic [DATA_W-1:0] dout_q, dout_d; // driven data word
   logic [TMO_W-1:0] tmo_q, tmo_d; // address accept wait counter
   logic buf_in_ready; // read buffer has room
   logic buf_push; // read word captured

   // an order is taken only when idle, and a read only with room for its word,
   // so a stalled receiver can never make a returning word fall on the floor
   assign cmd_ready = (phase_q == ST_IDLE) && (buf_in_ready || !cmd_read);
   assign buf_push = (phase_q == ST_READ_DATA) && channel_read_done_pulse; // R12

   // read words pass through a two-entry buffer toward the user
   word_buffer read_buffer (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(buf_push),
      .in_ready(buf_in_ready),
      .in_data(bus_data_in),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );

   // next state of the cycle sequencer and every pin it drives
   always_comb begin
      phase_d = phase_q;
      req_d = req_q;
      cyc_d = cyc_q;
      rdr_d = rdr_q;
      wrr_d = wrr_q;
      wdone_d = 1'b0;
      oe_d = 1'b0;
      abort_d = 1'b0;
      aseen_d = 1'b0;
      nopar_d = nopar_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      dout_d = dout_q;
      tmo_d = tmo_q;
      // parity loss is noted whenever the memory reports it in our cycle
      if (channel_no_parity_pulse && (phase_q != ST_IDLE)) begin
         nopar_d = 1'b1; // R24
      end
      case (phase_q)
         ST_IDLE: begin
            // an order with neither read nor write is dropped quietly
            if (cmd_valid && cmd_ready && (cmd_read || cmd_write)) begin
               addr_d = cmd_addr;
               wdata_d = cmd_wdata;
               rdr_d = cmd_read;
               wrr_d = cmd_write;
               nopar_d = 1'b0;
               req_d = 1'b1; // R01
               phase_d = ST_WAIT_GRANT;
            end
         end
         ST_WAIT_GRANT: begin
            // request stays up however long the grant takes
            if (grant_level) begin
               cyc_d = 1'b1; // R08
               tmo_d = TMO_ZERO;
               phase_d = ST_ADDRESS;
            end
         end
         ST_ADDRESS: begin
            if (channel_address_accept) begin
               cyc_d = 1'b0; // R10
               if (rdr_q) begin
                  phase_d = ST_READ_DATA;
               end else begin
                  phase_d = ST_WRITE_DATA;
               end
            end else if (tmo_q == NXM_TIMEOUT_CYC - TMO_ONE) begin
               cyc_d = 1'b0; // no memory answered: give the cycle up
               abort_d = 1'b1; // R22
               aseen_d = 1'b1;
               phase_d = ST_ABORT;
            end else begin
               tmo_d = tmo_q + TMO_ONE;
            end
         end
         ST_READ_DATA: begin
            // read-modify-write keeps the connection for its write half
            if (channel_read_done_pulse) begin
               if (wrr_q) begin
                  phase_d = ST_WRITE_DATA; // R25
               end else begin
                  phase_d = ST_RELEASE;
               end
            end
         end
         ST_WRITE_DATA: begin
            // word and its strobe leave together in the same cycle
            dout_d = wdata_q;
            oe_d = 1'b1; // R16
            wdone_d = 1'b1; // R16
            phase_d = ST_RELEASE;
         end
         ST_ABORT: begin
            phase_d = ST_RELEASE;
         end
         ST_RELEASE: begin
            // drop the request, then wait for the grant to fall so that a
            // new order is not mistaken for the old one still granted
            req_d = 1'b0;
            rdr_d = 1'b0;
            wrr_d = 1'b0;
            if (!req_q && !grant_level) begin
               phase_d = ST_IDLE;
            end
         end
         default: begin
            phase_d = ST_IDLE;
            req_d = 1'b0;
            cyc_d = 1'b0;
         end
      endcase
   end

   // register stage only
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         phase_q <= ST_IDLE;
         req_q <= 1'b0;
         cyc_q <= 1'b0;
         rdr_q <= 1'b0;
         wrr_q <= 1'b0;
         wdone_q <= 1'b0;
         oe_q <= 1'b0;
         abort_q <= 1'b0;
         aseen_q <= 1'b0;
         nopar_q <= 1'b0;
         addr_q <= ADDR_RESET;
         wdata_q <= DATA_RESET;
         dout_q <= DATA_RESET;
         tmo_q <= TMO_ZERO;
      end else begin
         phase_q <= phase_d;
         req_q <= req_d;
         cyc_q <= cyc_d;
         rdr_q <= rdr_d;
         wrr_q <= wrr_d;
         wdone_q <= wdone_d;
         oe_q <= oe_d;
         abort_q <= abort_d;
         aseen_q <= aseen_d;
         nopar_q <= nopar_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         dout_q <= dout_d;
         tmo_q <= tmo_d;
      end
   end

   // pins straight from flip-flops, except cycle_busy decoded from phase_q
   assign port_request = req_q;
   assign channel_cycle_request = cyc_q;
   assign bus_addr = addr_q;
   assign channel_read_request = rdr_q; // R11
   assign channel_write_request = wrr_q; // R11
   assign channel_write_done_pulse = wdone_q;
   assign bus_data_out = dout_q;
   assign bus_data_oe = oe_q;
   assign channel_abort_pulse = abort_q;
   assign abort_seen = aseen_q;
   assign no_parity_seen = nopar_q;
   assign cycle_busy = (phase_q != ST_IDLE);

   // request held while waiting for the grant
   a_request_held_ungranted: assert property (@(posedge clock) disable iff (!rst_n) // R01
      (phase_q == ST_WAIT_GRANT) && !grant_level |=> port_request)
      else $error("request dropped before grant");

   // cycle request only under a grant, with our request up
   a_cycle_after_grant: assert property (@(posedge clock) disable iff (!rst_n) // R08
      $rose(channel_cycle_request) |-> $past(grant_level) && port_request)
      else $error("cycle request without grant");

   // write strobe is one cycle wide and carries the held word on the bus
   a_write_word_strobe: assert property (@(posedge clock) disable iff (!rst_n) // R16
      channel_write_done_pulse |-> bus_data_oe && (bus_data_out == wdata_q) ##1 !channel_write_done_pulse)
      else $error("write strobe without its word");

   // abort fires exactly at the end of the accept wait
   a_abort_on_timeout: assert property (@(posedge clock) disable iff (!rst_n) // R22
      (phase_q == ST_ADDRESS) && !channel_address_accept && (tmo_q == NXM_TIMEOUT_CYC - TMO_ONE)
      |=> channel_abort_pulse && !channel_cycle_request ##1 !channel_abort_pulse)
      else $error("abort not issued after accept timeout");

   // no abort ever without a cycle request having been pending
   a_abort_has_cause: assert property (@(posedge clock) disable iff (!rst_n) // R22
      channel_abort_pulse |-> $past(channel_cycle_request))
      else $error("abort without pending cycle");
endmodule

// [bench/mux_device_model.sv]
`timescale 1ns/10ps
// one port of the multiplexor with a small memory behind it
module mux_device_model
   import mux_port_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst_n, // reset, active low
   input wire logic port_request, // request level
   output logic grant_level, // grant to this port
   input wire logic channel_abort_pulse, // channel gives up
   input wire logic channel_cycle_request, // cycle request
   input wire logic [ADDR_W-1:0] bus_addr, // address word
   input wire logic channel_read_request, // read level
   input wire logic channel_write_request, // write level
   output logic channel_address_accept, // address taken
   output logic channel_read_done_pulse, // read word valid
   output logic channel_no_parity_pulse, // no parity kept
   input wire logic channel_write_done_pulse, // write word valid
   input wire logic [DATA_W-1:0] bus_data_out, // channel data
   input wire logic bus_data_oe, // channel drives data
   output logic [DATA_W-1:0] bus_data_in, // data to channel
   input wire logic [7:0] accept_delay, // cycles before accept
   input wire logic absent, // no memory answers
   input wire logic no_parity // memory lacks parity
);
   logic [DATA_W-1:0] mem [16]; // only low address bits kept
   logic [3:0] slot; // address taken at accept
   // drive just after the edge, like the bench
   task automatic step();
      @(posedge clock);
      #1;
   endtask
   // one whole cycle, grant to release
   task automatic serve();
      int n;
      grant_level = 1'b1;
      n = 0;
      while (channel_cycle_request !== 1'b1 && n < 100) begin
         step();
         n++;
      end
      if (absent) begin
         // no accept ever; only the channel's abort ends the cycle
         n = 0;
         while (channel_abort_pulse !== 1'b1 && n < 600) begin
            step();
            n++;
         end
      end else begin
         repeat (accept_delay) step();
         slot = bus_addr[3:0];
         channel_address_accept = 1'b1;
         step();
         channel_address_accept = 1'b0;
         if (channel_read_request === 1'b1) begin
            bus_data_in = mem[slot];
            channel_read_done_pulse = 1'b1;
            channel_no_parity_pulse = no_parity;
            step();
            channel_read_done_pulse = 1'b0;
            channel_no_parity_pulse = 1'b0;
            // released bus shows the inverse, never a stale word
            bus_data_in = ~bus_data_in;
         end
         if (channel_write_request === 1'b1) begin
            // read-modify-write stays connected until the write word
            n = 0;
            while (!(channel_write_done_pulse === 1'b1 && bus_data_oe === 1'b1) && n < 100) begin
               step();
               n++;
            end
            mem[slot] = bus_data_out;
         end
      end
      grant_level = 1'b0;
      n = 0;
      while (port_request !== 1'b0 && n < 100) begin
         step();
         n++;
      end
   endtask
   // idle until a request is seen out of reset
   initial begin
      grant_level = 1'b0;
      channel_address_accept = 1'b0;
      channel_read_done_pulse = 1'b0;
      channel_no_parity_pulse = 1'b0;
      bus_data_in = DATA_RESET;
      for (int i = 0; i < 16; i++) mem[i] = DATA_RESET;
      forever begin
         step();
         if (rst_n === 1'b1 && port_request === 1'b1) serve();
      end
   end
endmodule

// [bench/channel_port_master_tb_top.sv]
`timescale 1ns/10ps
// directed orders against the multiplexor model
module channel_port_master_tb_top
   import mux_port_pkg::*;
();
   logic clock = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0, cmd_write = 1'b0, rd_ready = 1'b0;
   logic [ADDR_W-1:0] cmd_addr = ADDR_RESET, bus_addr;
   logic [DATA_W-1:0] cmd_wdata = DATA_RESET, rd_data, bus_data_in, bus_data_out;
   logic cmd_ready, rd_valid, abort_seen, no_parity_seen, cycle_busy, port_request, grant_level;
   logic channel_abort_pulse, channel_cycle_request, channel_read_request, channel_write_request;
   logic channel_address_accept, channel_read_done_pulse, channel_no_parity_pulse;
   logic channel_write_done_pulse, bus_data_oe;
   logic absent = 1'b0, no_parity = 1'b0; // model controls
   logic [7:0] accept_delay = 8'h00; // model's accept wait, a 4-state net on the model side
   int aborts = 0, miscompares = 0, checks = 0;
   always #12.5 clock = ~clock;
   channel_port_master u_dut (.clock, .rst_n, .cmd_valid, .cmd_ready, .cmd_read, .cmd_write, .cmd_addr,
      .cmd_wdata, .rd_valid, .rd_ready, .rd_data, .abort_seen, .no_parity_seen, .cycle_busy, .port_request,
      .grant_level, .channel_abort_pulse, .channel_cycle_request, .bus_addr, .channel_read_request,
      .channel_write_request, .channel_address_accept, .channel_read_done_pulse, .channel_no_parity_pulse,
      .channel_write_done_pulse, .bus_data_in, .bus_data_out, .bus_data_oe);
   mux_device_model u_model (.clock, .rst_n, .port_request, .grant_level, .channel_abort_pulse,
      .channel_cycle_request, .bus_addr, .channel_read_request, .channel_write_request, .channel_address_accept,
      .channel_read_done_pulse, .channel_no_parity_pulse, .channel_write_done_pulse, .bus_data_out,
      .bus_data_oe, .bus_data_in, .accept_delay, .absent, .no_parity);
   task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      if (miscompares == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // a wait that ran out counts as a mismatch and ends the run
   task automatic give_up(input string what);
      check(what, 1'b1, 1'b0);
      print_verdict();
   endtask
   task automatic step();
      @(posedge clock);
      #1;
   endtask
   // offer one order, then wait for the cycle to finish, counting aborts
   task automatic order(input logic r, input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      cmd_read = r;
      cmd_write = w;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_valid = 1'b1;
      n = 0;
      while (cmd_ready !== 1'b1) begin
         step();
         n++;
         if (n > 200) give_up("cmd_ready");
      end
      step();
      cmd_valid = 1'b0;
      n = 0;
      while (cycle_busy !== 1'b0) begin
         if (abort_seen === 1'b1) aborts++;
         step();
         n++;
         if (n > 1000) give_up("cycle_busy");
      end
   endtask
   // take the oldest read word and compare it
   task automatic pop(input logic [DATA_W-1:0] exp);
      int n;
      n = 0;
      while (rd_valid !== 1'b1) begin
         step();
         n++;
         if (n > 50) give_up("rd_valid");
      end
      check("rd_data", rd_data, exp);
      rd_ready = 1'b1;
      step();
      rd_ready = 1'b0;
      // let an edge pass so a following pop never re-raises the strobe in this time step
      step();
   endtask
   initial begin
      repeat (6) @(posedge clock);
      #1;
      rst_n = 1'b1;
      check("cmd_ready", cmd_ready, 1'b1);
      order(1'b0, 1'b1, 18'h00003, 36'h123456789);
      order(1'b1, 1'b0, 18'h00003, DATA_RESET);
      pop(36'h123456789);
      check("no_parity_seen", no_parity_seen, 1'b0);
      order(1'b1, 1'b1, 18'h00003, 36'h0abcdef01);
      pop(36'h123456789);
      no_parity = 1'b1;
      accept_delay = 8'h14;
      order(1'b1, 1'b0, 18'h00003, DATA_RESET);
      pop(36'h0abcdef01);
      check("no_parity_seen", no_parity_seen, 1'b1);
      no_parity = 1'b0;
      absent = 1'b1;
      order(1'b1, 1'b0, 18'h00005, DATA_RESET);
      check("abort_seen", aborts, 36'h000000001);
      check("rd_valid", rd_valid, 1'b0);
      check("no_parity_seen", no_parity_seen, 1'b0);
      absent = 1'b0;
      // user stalls: two words fill the buffer, a third read is held off
      order(1'b1, 1'b0, 18'h00003, DATA_RESET);
      order(1'b1, 1'b0, 18'h00000, DATA_RESET);
      cmd_read = 1'b1;
      #1;
      check("cmd_ready", cmd_ready, 1'b0);
      pop(36'h0abcdef01);
      pop(DATA_RESET);
      check("rd_valid", rd_valid, 1'b0);
      print_verdict();
   end
endmodule
